// ### inc/flash_prot_pkg.sv
// shared constants and types for the flash protection and status logic
package flash_prot_pkg;
	// command opcodes
	localparam logic [7:0] OP_RD_PROT = 8'h3c;
	localparam logic [7:0] OP_RD_STAT = 8'h05;
	localparam logic [7:0] OP_WR_STAT = 8'h01;
	localparam logic [7:0] OP_WREN = 8'h06;
	localparam logic [7:0] OP_WRDI = 8'h04;
	// address layout
	localparam int ADDR_BYTES = 3;
	localparam logic [1:0] ADDR_LAST = 2'h2;
	localparam int SECT_W_DEF = 5;
	localparam int SECT_LSB_DEF = 16;
	// device_status bit positions
	localparam int ST_LOCK = 7;
	localparam int ST_SEQ = 6;
	localparam int ST_ERR = 5;
	localparam int ST_PIN = 4;
	localparam int ST_SUM_HI = 3;
	localparam int ST_SUM_LO = 2;
	localparam int ST_WEL = 1;
	localparam int ST_BUSY = 0;
	// sector_protect_summary codes
	localparam logic [1:0] SUM_NONE = 2'h0;
	localparam logic [1:0] SUM_SOME = 2'h1;
	localparam logic [1:0] SUM_ALL = 2'h3;
	// global protect field of written data, bits 5:2
	localparam logic [3:0] GLOB_UNPROT = 4'h0;
	localparam logic [3:0] GLOB_PROT = 4'hf;
	// reset values
	localparam logic RST_LOCK = 1'b0;
	localparam logic RST_WEL = 1'b0;
	localparam logic RST_FLAG = 1'b1;
	localparam logic [2:0] BIT_LAST = 3'h7;
	// serial command states, gray along opcode->addr->prot
	typedef enum logic [2:0] {
		S_OPC = 3'b000,
		S_ADDR = 3'b001,
		S_PROT = 3'b011,
		S_STAT = 3'b010,
		S_WDATA = 3'b110,
		S_WDONE = 3'b111,
		S_HOLD = 3'b101
	} state_t;
endpackage

// ### hdl/pin_sync.sv
// two-flop synchroniser for a group of pin levels
`timescale 1ns/1ps
`default_nettype none
module pin_sync #(
	parameter int W = 1,
	parameter logic [W-1:0] RST_LEVEL = '0
) (
	input wire logic clock,
	input wire logic rst,
	input wire logic [W-1:0] pin,
	output logic [W-1:0] level
);
	logic [W-1:0] meta_r;

	// the first stage feeds the second stage only; reset to the idle level
	// so that no false edge follows reset
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			meta_r <= RST_LEVEL;
			level <= RST_LEVEL;
		end else begin
			meta_r <= pin;
			level <= meta_r;
		end
	end
endmodule
`default_nettype wire

// ### hdl/sector_flags.sv
// per-sector protection flags with registered read port
`timescale 1ns/1ps
`default_nettype none
module sector_flags #(
	parameter int SECT_W = 5
) (
	input wire logic clock,
	input wire logic rst,
	input wire logic glob_set,
	input wire logic glob_clr,
	input wire logic one_set,
	input wire logic one_clr,
	input wire logic [SECT_W-1:0] one_idx,
	input wire logic [SECT_W-1:0] rd_idx,
	output logic rd_flag,
	output logic [(1<<SECT_W)-1:0] flags
);
	// global operations take priority over single-sector requests
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			flags <= {(1<<SECT_W){flash_prot_pkg::RST_FLAG}};
		end else if (glob_set) begin
			flags <= '1;
		end else if (glob_clr) begin
			flags <= '0;
		end else if (one_set) begin
			flags[one_idx] <= 1'b1;
		end else if (one_clr) begin
			flags[one_idx] <= 1'b0;
		end
	end

	// read data registered; serial output needs it only edges later
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			rd_flag <= flash_prot_pkg::RST_FLAG;
		end else begin
			rd_flag <= flags[rd_idx];
		end
	end
endmodule
`default_nettype wire

// ### hdl/flash_protect_status_logic.sv
// serial protection-read, status read/write and locking logic
//
// Overview of operation
// RULE_01: opcode 3ch starts a sector protection-flag read.
// RULE_02: three address bytes follow; any address inside a sector selects it.
// RULE_03: after last address byte, output repeats ffh if protected, 00h if not.
// RULE_04: chip select release ends protection read and floats serial output.
// RULE_05: protection read shows only the stored flag, never the pin.
// RULE_06: hardware lock active only with pin low and lock bit one.
// RULE_07: under hardware lock ignore sector protect, unprotect and status writes.
// RULE_08: clearing the lock bit never performs a global protect or unprotect.
// RULE_09: with pin held low, a set lock bit clears only by reset.
// RULE_10: setting lock bit from zero also applies global op from bits 5:2.
// RULE_11: sector protected exactly when its flag is one, pin ignored.
// RULE_12: software lock allows lock clear but blocks sector and global ops.
// RULE_13: lock bit zero unlocks flags and allows setting the lock bit.
// RULE_14: status read accepted anytime, even while busy.
// RULE_15: opcode 05h then status bits shift out every clock.
// RULE_16: after bit 0 restart at bit 7 with fresh status sampled.
// RULE_17: chip select release ends status read and floats serial output.
// RULE_18: bit 7 lock bit, bit 6 sequential program mode.
// RULE_19: bit 5 reports last erase or program error.
// RULE_20: bit 4 reads 0 while pin asserted, 1 while deasserted.
// RULE_21: bits 3:2 none 00, some 01, all 11.
// RULE_22: bit 1 write enable latch, bit 0 busy.
// RULE_23: opcode 01h plus one data byte, extra ignored, applied at release.
// RULE_24: status write takes effect only with write enable latch set.
// RULE_25: unlocked, data 00h unprotects all, 7fh protects all, lock stays 0.
// RULE_26: lock bit is zero after reset.
// RULE_27: msb first, sample on rising clock, change output on falling clock.
// RULE_28: one flag per sector; summary derived combinationally from all flags.
`timescale 1ns/1ps
`default_nettype none
module flash_protect_status_logic #(
	parameter int SECT_W = flash_prot_pkg::SECT_W_DEF,
	parameter int SECT_LSB = flash_prot_pkg::SECT_LSB_DEF
) (
	input wire logic clock,
	input wire logic rst,
	input wire logic cs_n,
	input wire logic sck,
	input wire logic si,
	input wire logic wp_n,
	input wire logic busy,
	input wire logic prog_error,
	input wire logic seq_mode,
	input wire logic sect_prot_req,
	input wire logic sect_unprot_req,
	input wire logic [SECT_W-1:0] sect_req_idx,
	output logic so,
	output logic so_oe,
	output logic write_enable_latch,
	output logic protection_lock_bit
);
	localparam int NSECT = 1 << SECT_W;

	logic cs_n_s, sck_s, si_s, wp_n_s;
	logic sck_d_r, cs_d_r;
	flash_prot_pkg::state_t state_r, state_nxt;
	logic [7:0] shift_r, opcode_r, wdata_r, snap_r;
	logic [2:0] bit_cnt_r, out_idx_r;
	logic [1:0] addr_cnt_r;
	logic [23:0] addr_r;
	logic lock_r, wel_r, so_r, so_oe_r;
	logic rd_flag;
	logic [NSECT-1:0] flags;

	// every pin passes two flops before use; select and pin idle high
	pin_sync #(.W(4), .RST_LEVEL(4'h9)) u_sync (
		.clock(clock),
		.rst(rst),
		.pin({cs_n, sck, si, wp_n}),
		.level({cs_n_s, sck_s, si_s, wp_n_s})
	);

	// edge finding on the sampled serial clock and select
	wire sel = ~cs_n_s;
	wire sck_rise = sck_s & ~sck_d_r;
	wire sck_fall = ~sck_s & sck_d_r;
	wire cs_end = cs_n_s & ~cs_d_r;
	wire [7:0] byte_in = {shift_r[6:0], si_s}; // msb first [RULE_27]
	wire byte_done = sel & sck_rise & (bit_cnt_r == flash_prot_pkg::BIT_LAST);

	// command decode
	wire op_prot = byte_in == flash_prot_pkg::OP_RD_PROT; // [RULE_01]
	wire op_stat = byte_in == flash_prot_pkg::OP_RD_STAT; // [RULE_15]
	wire op_wsr = byte_in == flash_prot_pkg::OP_WR_STAT; // [RULE_23]
	wire last_addr = addr_cnt_r == flash_prot_pkg::ADDR_LAST;

	// locking terms
	wire hw_lock = ~wp_n_s & lock_r; // [RULE_06]
	wire wsr_go = cs_end & (state_r == flash_prot_pkg::S_WDONE) & wel_r; // [RULE_24]
	wire wsr_ok = wsr_go & ~hw_lock; // [RULE_07] [RULE_09]
	wire glob_en = wsr_ok & ~lock_r; // [RULE_08] [RULE_12] [RULE_13]
	wire [3:0] glob_code = wdata_r[5:2];
	wire glob_set = glob_en & (glob_code == flash_prot_pkg::GLOB_PROT); // [RULE_10] [RULE_25]
	wire glob_clr = glob_en & (glob_code == flash_prot_pkg::GLOB_UNPROT); // [RULE_25]
	wire one_set = sect_prot_req & ~lock_r; // [RULE_07] [RULE_12]
	wire one_clr = sect_unprot_req & ~lock_r; // [RULE_13]

	// write enable latch: set by 06h, cleared by 04h or any status write, even one cut short
	wire in_hold = state_r == flash_prot_pkg::S_HOLD;
	wire wel_set = cs_end & in_hold & (opcode_r == flash_prot_pkg::OP_WREN);
	wire wel_clr = cs_end & ((in_hold & (opcode_r == flash_prot_pkg::OP_WRDI))
		| (state_r == flash_prot_pkg::S_WDATA)
		| (state_r == flash_prot_pkg::S_WDONE));

	// summary is combinational over every flag [RULE_28] [RULE_21]
	wire all_prot = &flags;
	wire any_prot = |flags;
	wire [1:0] summary = all_prot ? flash_prot_pkg::SUM_ALL :
		(any_prot ? flash_prot_pkg::SUM_SOME : flash_prot_pkg::SUM_NONE);

	// live status byte [RULE_18] [RULE_19] [RULE_20] [RULE_22]
	wire [7:0] status_now = {lock_r, seq_mode, prog_error, wp_n_s,
		summary, wel_r, busy};
	wire stat_bit = (out_idx_r == flash_prot_pkg::BIT_LAST) ?
		status_now[flash_prot_pkg::ST_LOCK] : snap_r[out_idx_r];

	// sector selected by the address bits above the sector size [RULE_02]
	wire [SECT_W-1:0] rd_idx = addr_r[SECT_LSB +: SECT_W];

	sector_flags #(.SECT_W(SECT_W)) u_flags (
		.clock(clock),
		.rst(rst),
		.glob_set(glob_set),
		.glob_clr(glob_clr),
		.one_set(one_set),
		.one_clr(one_clr),
		.one_idx(sect_req_idx),
		.rd_idx(rd_idx),
		.rd_flag(rd_flag),
		.flags(flags)
	);

	// next command state; release of select always returns to opcode
	always_comb begin
		state_nxt = state_r;
		if (!sel) begin
			state_nxt = flash_prot_pkg::S_OPC;
		end else if (byte_done) begin
			case (state_r)
				flash_prot_pkg::S_OPC: begin
					if (op_prot)
						state_nxt = flash_prot_pkg::S_ADDR;
					else if (op_stat)
						state_nxt = flash_prot_pkg::S_STAT; // [RULE_14]
					else if (op_wsr)
						state_nxt = flash_prot_pkg::S_WDATA;
					else
						state_nxt = flash_prot_pkg::S_HOLD;
				end
				flash_prot_pkg::S_ADDR: begin
					if (last_addr)
						state_nxt = flash_prot_pkg::S_PROT; // [RULE_02]
				end
				flash_prot_pkg::S_WDATA: begin
					state_nxt = flash_prot_pkg::S_WDONE; // extra bytes ignored [RULE_23]
				end
				default: begin
					state_nxt = state_r;
				end
			endcase
		end
	end

	// serial input side: shifter, bit count, state
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			sck_d_r <= 1'b0;
			cs_d_r <= 1'b1;
			state_r <= flash_prot_pkg::S_OPC;
			shift_r <= 8'h00;
			bit_cnt_r <= 3'h0;
		end else begin
			sck_d_r <= sck_s;
			cs_d_r <= cs_n_s;
			state_r <= state_nxt;
			if (!sel)
				bit_cnt_r <= 3'h0;
			else if (sck_rise) begin
				bit_cnt_r <= bit_cnt_r + 3'h1;
				shift_r <= byte_in;
			end
		end
	end

	// captured opcode, address and written data byte
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			opcode_r <= 8'h00;
			wdata_r <= 8'h00;
			addr_r <= 24'h000000;
			addr_cnt_r <= 2'h0;
		end else begin
			if (byte_done && state_r == flash_prot_pkg::S_OPC)
				opcode_r <= byte_in;
			if (byte_done && state_r == flash_prot_pkg::S_WDATA)
				wdata_r <= byte_in;
			if (!sel)
				addr_cnt_r <= 2'h0;
			else if (byte_done && state_r == flash_prot_pkg::S_ADDR) begin
				addr_cnt_r <= addr_cnt_r + 2'h1;
				addr_r <= {addr_r[15:0], byte_in};
			end
		end
	end

	// serial output changes only after falling clock edges or on release of select [RULE_27]
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			so_r <= 1'b0;
			so_oe_r <= 1'b0;
			out_idx_r <= flash_prot_pkg::BIT_LAST;
			snap_r <= 8'h00;
		end else if (!sel) begin
			so_oe_r <= 1'b0; // release floats the pin [RULE_04] [RULE_17]
			so_r <= 1'b0;
			out_idx_r <= flash_prot_pkg::BIT_LAST;
		end else if (sck_fall) begin
			if (state_r == flash_prot_pkg::S_PROT) begin
				so_oe_r <= 1'b1;
				so_r <= rd_flag; // every bit the flag [RULE_03] [RULE_05] [RULE_11]
			end else if (state_r == flash_prot_pkg::S_STAT) begin
				so_oe_r <= 1'b1;
				so_r <= stat_bit; // [RULE_15]
				out_idx_r <= out_idx_r - 3'h1; // wraps 0 to 7 [RULE_16]
				if (out_idx_r == flash_prot_pkg::BIT_LAST)
					snap_r <= status_now; // fresh per repetition [RULE_16]
			end
		end
	end

	// lock bit and write enable latch
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			lock_r <= flash_prot_pkg::RST_LOCK; // [RULE_26] [RULE_09]
			wel_r <= flash_prot_pkg::RST_WEL;
		end else begin
			if (wsr_ok)
				lock_r <= wdata_r[flash_prot_pkg::ST_LOCK]; // [RULE_12] [RULE_13]
			if (wel_set)
				wel_r <= 1'b1;
			else if (wel_clr)
				wel_r <= 1'b0; // [RULE_24]
		end
	end

	assign so = so_r;
	assign so_oe = so_oe_r;
	assign write_enable_latch = wel_r;
	assign protection_lock_bit = lock_r;

	// checks
	default clocking @(posedge clock); endclocking
	default disable iff (rst);

	property p_hw_lock_hold;
		wsr_go && hw_lock |=> $stable(lock_r) && $stable(flags);
	endproperty
	a_hw_lock_hold: assert property (p_hw_lock_hold) // [RULE_07]
		else $error("status write changed state under hardware lock");

	property p_no_global_on_clear;
		wsr_go && lock_r |=> $stable(flags);
	endproperty
	a_no_global_on_clear: assert property (p_no_global_on_clear) // [RULE_08]
		else $error("global op applied while lock bit was set");

	property p_global_protect;
		wsr_ok && !lock_r && glob_code == 4'hf |=> &flags;
	endproperty
	a_global_protect: assert property (p_global_protect) // [RULE_10]
		else $error("global protect not applied");

	property p_release_float;
		$rose(cs_n_s) |=> !so_oe;
	endproperty
	a_release_float: assert property (p_release_float) // [RULE_17]
		else $error("output still driven after release");

	property p_prot_value;
		so_oe && state_r == flash_prot_pkg::S_PROT |-> so == rd_flag;
	endproperty
	a_prot_value: assert property (p_prot_value) // [RULE_03]
		else $error("protection read output differs from flag");

	property p_summary_code;
		(all_prot |-> summary == 2'h3) and (!any_prot |-> summary == 2'h0);
	endproperty
	a_summary_code: assert property (p_summary_code) // [RULE_21]
		else $error("summary bits wrong");

	property p_pin_bit;
		!$past(rst) && !$past(rst, 2) |->
			status_now[flash_prot_pkg::ST_PIN] == $past(wp_n, 2);
	endproperty
	a_pin_bit: assert property (p_pin_bit) // [RULE_20]
		else $error("pin level bit wrong");

	property p_locked_sector;
		lock_r && (sect_prot_req || sect_unprot_req) && !glob_en |=>
			$stable(flags);
	endproperty
	a_locked_sector: assert property (p_locked_sector) // [RULE_12]
		else $error("sector flag changed while locked");

	property p_wel_needed;
		cs_end && state_r == flash_prot_pkg::S_WDONE && !wel_r |=>
			$stable(lock_r) && $stable(flags);
	endproperty
	a_wel_needed: assert property (p_wel_needed) // [RULE_24]
		else $error("status write applied without write enable");

	property p_stat_enter;
		byte_done && state_r == flash_prot_pkg::S_OPC && op_stat |=>
			state_r == flash_prot_pkg::S_STAT ##0 !so_oe;
	endproperty
	a_stat_enter: assert property (p_stat_enter) // [RULE_15]
		else $error("status read not entered after opcode");

	c_prot_read: cover property (so_oe && state_r == flash_prot_pkg::S_PROT);
	c_stat_wrap: cover property (sck_fall && state_r == flash_prot_pkg::S_STAT
		&& out_idx_r == 3'h0);
	c_lock_set: cover property (wsr_ok && !lock_r && wdata_r[7]);
	c_hw_ignored: cover property (wsr_go && hw_lock);
endmodule
`default_nettype wire

// ### test/spi_host.sv
// host serial master model that drives the flash pins in mode 0
`timescale 1ns/1ps
`default_nettype none
module spi_host (
	input wire logic clock,
	input wire logic so,
	output logic cs_n,
	output logic sck,
	output logic si
);
	// idle: deselected, clock parked low
	initial begin
		cs_n = 1'b1;
		sck = 1'b0;
		si = 1'b0;
	end
	// open a frame, leave setup time before the first bit
	task automatic frame_on();
		@(posedge clock);
		cs_n <= 1'b0;
		repeat (4) @(posedge clock);
	endtask
	// si flips on release so a stale bit never looks like data
	task automatic frame_off();
		repeat (4) @(posedge clock);
		cs_n <= 1'b1;
		si <= ~si;
		repeat (8) @(posedge clock);
	endtask
	// n bits, msb first; so read mid high phase, it only moves on fall
	task automatic shift(input int n, input logic [7:0] tx,
		output logic [7:0] rx);
		rx = 8'h00;
		for (int i = 7; i > 7 - n; i--) begin
			si <= tx[i];
			repeat (4) @(posedge clock);
			sck <= 1'b1;
			repeat (2) @(posedge clock);
			rx[i] = so;
			repeat (2) @(posedge clock);
			sck <= 1'b0;
		end
	endtask
endmodule
`default_nettype wire

// ### test/test_flash_protect_status_logic.sv
// self-checking bench for the protection and status logic
`timescale 1ns/1ps
`default_nettype none
module test_flash_protect_status_logic;
	logic clock = 1'b0;
	logic rst = 1'b1;
	logic cs_n, sck, si, so, so_oe;
	logic write_enable_latch, protection_lock_bit;
	logic wp_n = 1'b1;
	logic busy = 1'b0;
	logic prog_error = 1'b0;
	logic seq_mode = 1'b0;
	logic sect_prot_req = 1'b0;
	logic sect_unprot_req = 1'b0;
	logic [4:0] sect_req_idx = 5'h00;
	logic [7:0] rx;
	int n_fail = 0;
	int n_tests = 0;
	// an undriven line reads the inverse, never the stale bit
	wire so_line = so_oe ? so : ~so;
	always #10 clock = ~clock;
	spi_host host (.clock, .so(so_line), .cs_n, .sck, .si);
	flash_protect_status_logic #(.SECT_W(5), .SECT_LSB(16)) dut (
		.clock, .rst, .cs_n, .sck, .si, .wp_n, .busy, .prog_error,
		.seq_mode, .sect_prot_req, .sect_unprot_req, .sect_req_idx,
		.so, .so_oe, .write_enable_latch, .protection_lock_bit);
	task automatic conclude();
		if (n_fail == 0 && n_tests > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask
	task automatic cmp8(input logic [7:0] got, input logic [7:0] exp);
		n_tests++;
		if (got !== exp) begin
			n_fail++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic cmp1(input logic got, input logic exp);
		n_tests++;
		if (got !== exp) begin
			n_fail++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic cmd(input logic [7:0] op);
		host.frame_on();
		host.shift(8, op, rx);
		host.frame_off();
	endtask
	// trailing byte after the data must be ignored
	task automatic wr_raw(input logic [7:0] d);
		host.frame_on();
		host.shift(8, flash_prot_pkg::OP_WR_STAT, rx);
		host.shift(8, d, rx);
		host.shift(8, 8'h00, rx);
		host.frame_off();
	endtask
	task automatic wr_stat(input logic [7:0] d);
		cmd(flash_prot_pkg::OP_WREN);
		wr_raw(d);
	endtask
	task automatic rd_stat(input logic [7:0] exp);
		host.frame_on();
		host.shift(8, flash_prot_pkg::OP_RD_STAT, rx);
		host.shift(8, 8'h00, rx);
		cmp8(rx, exp);
		host.frame_off();
	endtask
	// two output bytes, then release must float the pin
	task automatic rd_prot(input logic [23:0] a, input logic [7:0] exp);
		host.frame_on();
		host.shift(8, flash_prot_pkg::OP_RD_PROT, rx);
		host.shift(8, a[23:16], rx);
		host.shift(8, a[15:8], rx);
		host.shift(8, a[7:0], rx);
		host.shift(8, 8'h00, rx);
		cmp8(rx, exp);
		host.shift(8, 8'h00, rx);
		cmp8(rx, exp);
		cmp1(so_oe, 1'b1);
		host.frame_off();
		cmp1(so_oe, 1'b0);
	endtask
	// one-cycle protect or unprotect request from command logic
	task automatic pulse(input logic p, input logic [4:0] idx);
		@(posedge clock);
		sect_prot_req <= p;
		sect_unprot_req <= ~p;
		sect_req_idx <= idx;
		@(posedge clock);
		sect_prot_req <= 1'b0;
		sect_unprot_req <= 1'b0;
		repeat (2) @(posedge clock);
	endtask
	// whole run is under 10k cycles; this limit only cuts a hang
	initial begin
		#400000;
		n_fail++;
		conclude();
	end
	initial begin
		repeat (16) @(posedge clock);
		rst <= 1'b0;
		repeat (4) @(posedge clock);
		cmp1(protection_lock_bit, 1'b0);
		rd_stat(8'h1c);
		// status bits follow their sources, refreshed per repeat
		busy <= 1'b1;
		prog_error <= 1'b1;
		seq_mode <= 1'b1;
		host.frame_on();
		host.shift(8, flash_prot_pkg::OP_RD_STAT, rx);
		host.shift(8, 8'h00, rx);
		cmp8(rx, 8'h7d);
		busy <= 1'b0;
		prog_error <= 1'b0;
		seq_mode <= 1'b0;
		host.shift(8, 8'h00, rx);
		cmp8(rx, 8'h1c);
		host.frame_off();
		rd_prot(24'h030000, 8'hff);
		wp_n <= 1'b0;
		rd_prot(24'h03ffff, 8'hff);
		wp_n <= 1'b1;
		wr_stat(8'h00);
		rd_stat(8'h10);
		rd_prot(24'h1f0000, 8'h00);
		wr_raw(8'h7f);
		rd_stat(8'h10);
		// unknown opcode leaves the latch, 04h drops it
		cmd(flash_prot_pkg::OP_WREN);
		cmd(8'h5a);
		cmp1(write_enable_latch, 1'b1);
		cmd(flash_prot_pkg::OP_WRDI);
		cmp1(write_enable_latch, 1'b0);
		// data byte cut short: abort, latch dropped
		cmd(flash_prot_pkg::OP_WREN);
		cmp1(write_enable_latch, 1'b1);
		host.frame_on();
		host.shift(8, flash_prot_pkg::OP_WR_STAT, rx);
		host.shift(4, 8'hff, rx);
		host.frame_off();
		rd_stat(8'h10);
		pulse(1'b1, 5'h05);
		rd_stat(8'h14);
		rd_prot(24'h05ffff, 8'hff);
		rd_prot(24'h04ffff, 8'h00);
		wr_stat(8'hff);
		cmp1(protection_lock_bit, 1'b1);
		rd_stat(8'h9c);
		pulse(1'b0, 5'h05);
		rd_stat(8'h9c);
		wr_stat(8'h00);
		rd_stat(8'h1c);
		wr_stat(8'hf0);
		wp_n <= 1'b0;
		rd_stat(8'h8c);
		wr_stat(8'h00);
		cmp1(write_enable_latch, 1'b0);
		pulse(1'b0, 5'h02);
		rd_stat(8'h8c);
		// with the pin still low, a second reset is the only way out of the hardware lock
		@(posedge clock);
		rst <= 1'b1;
		repeat (2) @(posedge clock);
		rst <= 1'b0;
		repeat (4) @(posedge clock);
		rd_stat(8'h0c);
		// release part way through an output byte
		host.frame_on();
		host.shift(8, flash_prot_pkg::OP_RD_STAT, rx);
		host.shift(3, 8'h00, rx);
		host.frame_off();
		cmp1(so_oe, 1'b0);
		conclude();
	end
endmodule
`default_nettype wire
